// [tb/test_uml_modem_lines.sv]
`timescale 1ns/1ps
`default_nettype none
module test_uml_modem_lines
    import uml_pkg::*;
;
    logic        clk = 1'h0, rst_n = 1'h0, mrst = 1'h0, rd = 1'h0, wr = 1'h0;
    logic [2:0]  addr = 3'h0;
    logic [7:0]  din = 8'h00, dout;
    logic [4:0]  src = 5'h00;
    logic [1:0]  want = 2'h0;
    logic [3:0]  lag = 4'h0;
    logic        oe, bus_driver_disable_n_n, irq, txa, cts_n, dsr_n, dcd_n, dtr_n, rts_n, ua_n, ub_n;
    logic [31:0] seed = 32'h57;
    logic [15:0] expq[$];
    logic [13:0] tbl[7] = '{14'h045, 14'h059, 14'h048, 14'h0a1, 14'h103, 14'h03e, 14'h184};
    int          err_count = 0, n_compared = 0, cyc = 0, rd_cnt = 0;

    uml_modem_lines dut (.ref_clk_in(clk), .rst_n_in(rst_n), .master_reset_in(mrst), .host_addr_in(addr),
        .host_rd_in(rd), .host_wr_in(wr), .host_data_bus_in(din), .host_data_bus_out(dout),
        .host_data_bus_oe_out(oe), .bus_driver_disable_n_out(bus_driver_disable_n_n), .int_out(irq), .rx_error_in(src[0]),
        .rx_data_avail_in(src[1]), .rx_timeout_in(src[2]), .fifo_mode_in(src[3]), .thr_empty_in(src[4]),
        .tx_allowed_out(txa), .cts_n_in(cts_n), .dsr_n_in(dsr_n), .dcd_n_in(dcd_n), .dtr_n_out(dtr_n),
        .rts_n_out(rts_n), .user_output_a_n_out(ua_n), .user_output_b_n_out(ub_n));
    uml_modem_partner modem (.ref_clk_in(clk), .rst_n_in(rst_n), .dtr_n_in(dtr_n), .want_in(want),
        .lag_in(lag), .cts_n_out(cts_n), .dsr_n_out(dsr_n), .dcd_n_out(dcd_n));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        xs = t ^ (t << 5);
    endfunction
    // status levels as the modem lines stand now, change flags left clear
    function automatic logic [7:0] lv();
        lv = {~dcd_n, 1'h0, ~dsr_n, ~cts_n, 4'h0};
    endfunction
    function automatic logic [7:0] pv();
        pv = {dtr_n, rts_n, ua_n, ub_n, irq, txa, bus_driver_disable_n_n, oe};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // waits past the edge so registered outputs have landed
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        din <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    // read held two edges, then dropped a full cycle before the next
    task automatic rreg(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        expq.push_back({m, e});
        repeat (2) @(posedge clk);
        rd <= 1'h0;
    endtask
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial forever #5 clk = ~clk;

    // read data is taken once per read, half a cycle after the snapshot edge
    always @(posedge clk) rd_cnt <= rd ? rd_cnt + 1 : 0;
    always @(negedge clk) begin
        logic [15:0] n;
        if (rd && rd_cnt == 1) begin
            n = expq.pop_front();
            chk(dout & n[15:8], n[7:0] & n[15:8], "read data");
            chk({6'h0, oe, bus_driver_disable_n_n}, 8'h02, "read strobes");
        end
    end

    // hang guard, far above the few hundred cycles needed
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            $display("ERROR %0t timeout", $time);
            complete_run();
        end
    end

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        tick(1);
        chk(pv(), 8'hf6, "reset levels");
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            wreg(ADDR_MCR, 8'(i));
            tick(1);
            chk(pv(), {~i[0], ~i[1], ~i[2], ~i[3], 4'h6}, "control pins");
        end
        wreg(ADDR_MCR, 8'h1f);
        tick(1);
        chk(pv(), 8'hf6, "loopback pins");
        $display("test control done");
        wreg(ADDR_MCR, 8'h00);
        seed = xs(seed);
        lag <= seed[3:0];
        tick(40);
        rreg(ADDR_MSR, 8'h00, 8'h00);
        rreg(ADDR_MSR, lv(), 8'hff);
        @(posedge clk);
        want <= 2'h3;
        tick(40);
        rreg(ADDR_MSR, lv() | 8'h09, 8'hff);
        rreg(ADDR_MSR, lv(), 8'hff);
        wreg(ADDR_MCR, 8'h01);
        tick(40);
        rreg(ADDR_MSR, lv() | 8'h02, 8'hff);
        $display("test status done");
        wreg(ADDR_IER, 8'h08);
        rreg(ADDR_MSR, 8'h00, 8'h00);
        @(posedge clk);
        want <= 2'h2;
        tick(25);
        chk({7'h0, irq}, 8'h01, "carrier irq");
        rreg(ADDR_MSR, lv() | 8'h08, 8'hff);
        tick(2);
        chk({7'h0, irq}, 8'h00, "irq after read");
        wreg(ADDR_MCR, 8'h21);
        rreg(ADDR_MSR, 8'h00, 8'h00);
        @(posedge clk);
        want <= 2'h0;
        tick(25);
        chk({6'h0, irq, txa}, 8'h00, "auto send held");
        @(posedge clk);
        want <= 2'h2;
        tick(25);
        chk({7'h0, txa}, 8'h01, "auto send open");
        wreg(ADDR_MCR, 8'h01);
        rreg(ADDR_MSR, 8'h00, 8'h00);
        @(posedge clk);
        want <= 2'h0;
        tick(25);
        chk({7'h0, irq}, 8'h01, "send change irq");
        @(posedge clk);
        mrst <= 1'h1;
        @(posedge clk);
        mrst <= 1'h0;
        tick(1);
        chk(pv(), 8'hf6, "master reset");
        $display("test interrupt done");
        foreach (tbl[k]) begin
            wreg(ADDR_IER, tbl[k][13:6]);
            @(posedge clk);
            src <= tbl[k][5:1];
            tick(3);
            chk({7'h0, irq}, {7'h0, tbl[k][0]}, "source irq");
            @(posedge clk);
            src <= 5'h00;
            tick(3);
            chk({7'h0, irq}, 8'h00, "source gone");
        end
        $display("test sources done");
        for (int k = 0; k < 4; k++) begin
            seed = xs(seed);
            wreg(ADDR_SCR, seed[7:0]);
            wreg(3'h2, seed[15:8]);
            rreg(ADDR_SCR, seed[7:0], 8'hff);
            rreg(3'h2, 8'h00, 8'hff);
        end
        tick(4);
        $display("test bus done");
        complete_run();
    end
endmodule // test_uml_modem_lines
`default_nettype wire

// [tb/uml_modem_lines_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module uml_modem_lines_properties
    import uml_pkg::*;
(
    input wire logic              ref_clk_in,
    input wire logic              rst_n_in,
    input wire logic              master_reset_in,
    input wire logic [ADDR_W-1:0] host_addr_in,
    input wire logic              host_rd_in,
    input wire logic              host_wr_in,
    input wire logic [DATA_W-1:0] host_data_bus_in,
    input wire logic [DATA_W-1:0] host_data_bus_out,
    input wire logic              host_data_bus_oe_out,
    input wire logic              bus_driver_disable_n_out,
    input wire logic              int_out,
    input wire logic              tx_allowed_out,
    input wire logic              cts_n_in,
    input wire logic              dcd_n_in,
    input wire logic              dtr_n_out,
    input wire logic              rts_n_out,
    input wire logic              user_output_a_n_out,
    input wire logic              user_output_b_n_out
);
    logic      loop_q;
    logic      auto_q;
    logic      ms_q;
    wire logic mcr_wr = host_wr_in && host_addr_in == ADDR_MCR;
    wire logic ier_wr = host_wr_in && host_addr_in == ADDR_IER;

    // shadow of the mode bits; master reset beats a write in the same cycle
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            loop_q <= 1'h0;
            auto_q <= 1'h0;
            ms_q   <= 1'h0;
        end else if (master_reset_in) begin
            loop_q <= 1'h0;
            auto_q <= 1'h0;
            ms_q   <= 1'h0;
        end else begin
            if (mcr_wr) begin
                loop_q <= host_data_bus_in[MCR_LOOP];
                auto_q <= host_data_bus_in[MCR_AUTO];
            end
            if (ier_wr) begin
                ms_q <= host_data_bus_in[IER_MS];
            end
        end
    end

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    a_bus_driver_disable_n_low_read: assert property (bus_driver_disable_n_out == !host_rd_in)
        else $error("driver disable not the inverse of read");
    a_bus_drive_read: assert property (host_data_bus_oe_out == host_rd_in)
        else $error("bus driven outside a read");
    a_mreset_int_low: assert property (master_reset_in |=> !int_out)
        else $error("interrupt survives master reset");
    a_mreset_pins_high: assert property (master_reset_in |=> dtr_n_out && rts_n_out && user_output_a_n_out
        && user_output_b_n_out && tx_allowed_out)
        else $error("outputs not inactive after master reset");
    a_loop_pins_high: assert property (loop_q |=> dtr_n_out && user_output_a_n_out && user_output_b_n_out)
        else $error("modem outputs active in loopback");
    a_ctrl_drives_pins: assert property (mcr_wr && !master_reset_in && !host_data_bus_in[MCR_LOOP]
        ##1 !master_reset_in |=> dtr_n_out == !$past(host_data_bus_in[MCR_DTR], 2)
        && user_output_a_n_out == !$past(host_data_bus_in[MCR_OUT_A], 2)
        && user_output_b_n_out == !$past(host_data_bus_in[MCR_OUT_B], 2))
        else $error("control bits not on output pins");
    a_msr_cts_level: assert property ($rose(host_rd_in) && host_addr_in == ADDR_MSR && !loop_q
        && !$past(loop_q) && $stable(cts_n_in) |=> host_data_bus_out[MSR_CTS] == !$past(cts_n_in)
        && host_data_bus_out[2] == 1'h0 && host_data_bus_out[6] == 1'h0)
        else $error("status read shows wrong send level");
    a_tx_open_noauto: assert property (!auto_q && !$past(auto_q) |-> tx_allowed_out)
        else $error("transmitter blocked without automatic mode");
    a_tx_closed_cts: assert property (auto_q && $past(auto_q) && !loop_q && !$past(loop_q)
        && !$past(loop_q, 2) && cts_n_in && $past(cts_n_in) && $past(cts_n_in, 2) |-> !tx_allowed_out)
        else $error("transmitter open while send is withheld");
    a_int_dcd_change: assert property (ms_q && !loop_q && $changed(dcd_n_in) && !host_rd_in
        && !master_reset_in |-> ##[1:3] int_out)
        else $error("carrier change raised no interrupt");
endmodule // uml_modem_lines_properties

bind uml_modem_lines uml_modem_lines_properties u_props (.*);
`default_nettype wire

// [tb/uml_modem_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module uml_modem_partner (
    input  wire logic       ref_clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       dtr_n_in,
    input  wire logic [1:0] want_in,
    input  wire logic [3:0] lag_in,
    output var  logic       cts_n_out,
    output var  logic       dsr_n_out,
    output var  logic       dcd_n_out
);
    logic [3:0] wait_reg;

    // modem answers dtr with dsr, and asked levels on send and carrier, after lag_in cycles
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wait_reg  <= 4'h0;
            cts_n_out <= 1'h1;
            dsr_n_out <= 1'h1;
            dcd_n_out <= 1'h1;
        end else if ({cts_n_out, dcd_n_out, dsr_n_out} == {~want_in, dtr_n_in}) begin
            wait_reg <= 4'h0;
        end else if (wait_reg >= lag_in) begin
            wait_reg  <= 4'h0;
            cts_n_out <= ~want_in[1];
            dcd_n_out <= ~want_in[0];
            dsr_n_out <= dtr_n_in;
        end else begin
            wait_reg <= wait_reg + 4'h1;
        end
    end
endmodule // uml_modem_partner
`default_nettype wire

// [verilog/uml_change_flag.sv]
`timescale 1ns/1ps
`default_nettype none
module uml_change_flag
    import uml_pkg::*;
(
    input  wire logic ref_clk_in,
    input  wire logic rst_n_in,
    input  wire logic master_reset_in,
    input  wire logic level_in,
    input  wire logic clear_in,
    output var  logic flag_out
);

    logic level_prev_reg;
    logic flag_reg;

    // last seen level, parked at inactive on reset
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            level_prev_reg <= 1'b0;
        end else if (master_reset_in) begin
            level_prev_reg <= 1'b0;
        end else begin
            level_prev_reg <= level_in;
        end
    end

    // sticky change flag; a change seen while clearing still sets it
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flag_reg <= 1'b0;
        end else if (master_reset_in) begin
            flag_reg <= 1'b0;
        end else if (level_in != level_prev_reg) begin
            flag_reg <= 1'b1;
        end else if (clear_in) begin
            flag_reg <= 1'b0;
        end
    end

    assign flag_out = flag_reg;

endmodule // uml_change_flag
`default_nettype wire

// [verilog/uml_host_port.sv]
`timescale 1ns/1ps
`default_nettype none
module uml_host_port
    import uml_pkg::*;
(
    input  wire logic              ref_clk_in,
    input  wire logic              rst_n_in,
    input  wire logic              host_rd_in,
    input  wire logic [DATA_W-1:0] read_value_in,
    output var  logic [DATA_W-1:0] data_out,
    output logic                   data_oe_out,
    output logic                   bus_driver_disable_n_out,
    output logic                   rd_start_out
);

    logic              rd_prev_reg;
    logic [DATA_W-1:0] data_reg;

    // read start is the first cycle of a read strobe
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_prev_reg <= 1'b0;
        end else begin
            rd_prev_reg <= host_rd_in;
        end
    end

    assign rd_start_out = host_rd_in & ~rd_prev_reg;

    // snapshot once per read so a clear-on-read cannot alter the byte mid-read
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            data_reg <= BYTE_ZERO;
        end else if (rd_start_out) begin
            data_reg <= read_value_in;
        end
    end

    // drive the bus and open the transceiver only while reading
    assign data_out                 = data_reg;
    assign data_oe_out              = host_rd_in;
    assign bus_driver_disable_n_out = ~host_rd_in;

endmodule // uml_host_port
`default_nettype wire

// [verilog/uml_modem_lines.sv]
// Function
// - The clear-to-send level reads back as modem status bit 4.
// - A clear-to-send change raises the modem status interrupt only when automatic clear-to-send is off.
// - With automatic clear-to-send on, the clear-to-send level gates the transmitter.
// - Carrier detect reads as status bit 7 and a change since the last status read sets bit 3.
// - Data-set-ready reads as status bit 5 and a change since the last status read sets bit 1.
// - A data-set-ready or carrier detect change raises the interrupt when modem status interrupts are enabled.
// - The driver-disable output is low during a host read and high otherwise.
// - The terminal-ready output is low when its control bit is set and high on reset, in loopback or when cleared.
// - The interrupt output is high while any enabled source is pending.
// - The interrupt output drops once the pending source is serviced or on master reset.
// - Each user output is low when its control bit (2 or 3) is set and high on reset, in loopback or when cleared.
// - The eight-bit host bus is driven only during host reads.
// - Master reset clears the registers other than scratch and forces outputs to their inactive levels.
`timescale 1ns/1ps
`default_nettype none
module uml_modem_lines
    import uml_pkg::*;
(
    input  wire logic              ref_clk_in,
    input  wire logic              rst_n_in,
    input  wire logic              master_reset_in,
    // host side
    input  wire logic [ADDR_W-1:0] host_addr_in,
    input  wire logic              host_rd_in,
    input  wire logic              host_wr_in,
    input  wire logic [DATA_W-1:0] host_data_bus_in,
    output logic      [DATA_W-1:0] host_data_bus_out,
    output logic                   host_data_bus_oe_out,
    output logic                   bus_driver_disable_n_out,
    output var logic               int_out,
    // interrupt sources from the neighbouring serial path
    input  wire logic              rx_error_in,
    input  wire logic              rx_data_avail_in,
    input  wire logic              rx_timeout_in,
    input  wire logic              fifo_mode_in,
    input  wire logic              thr_empty_in,
    // transmitter gate toward the serial path
    output var logic               tx_allowed_out,
    // modem side, all active low
    input  wire logic              cts_n_in,
    input  wire logic              dsr_n_in,
    input  wire logic              dcd_n_in,
    output var logic               dtr_n_out,
    output var logic               rts_n_out,
    output var logic               user_output_a_n_out,
    output var logic               user_output_b_n_out
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] int_enable_reg;
    logic [DATA_W-1:0] modem_control_reg;
    logic [DATA_W-1:0] scratch_reg;
    logic [DATA_W-1:0] modem_status_reg;
    logic [DATA_W-1:0] read_value;

    logic              loopback;
    logic              auto_cts;
    logic              cts_level;
    logic              dsr_level;
    logic              dcd_level;
    logic              cts_change;
    logic              dsr_change_flag;
    logic              dcd_change;
    logic              status_clear;
    logic              rd_start;
    logic              ms_pending;
    logic              rx_pending;
    logic              int_next;
    logic              tx_allowed_next;

    // ------------------------------------------------------------------
    // host writes to control registers
    // ------------------------------------------------------------------

    // interrupt enables; only the low nibble exists
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            int_enable_reg <= IER_RST;
        end else if (master_reset_in) begin
            int_enable_reg <= IER_RST;
        end else if (host_wr_in && uml_addr_hit(host_addr_in, ADDR_IER)) begin
            int_enable_reg <= host_data_bus_in & IER_MASK;
        end
    end

    // modem control bits: lines, loopback and automatic clear-to-send
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            modem_control_reg <= MCR_RST;
        end else if (master_reset_in) begin
            modem_control_reg <= MCR_RST;
        end else if (host_wr_in && uml_addr_hit(host_addr_in, ADDR_MCR)) begin
            modem_control_reg <= host_data_bus_in & MCR_MASK;
        end
    end

    // scratch byte, software only; survives master reset like the classic part
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            scratch_reg <= SCR_RST;
        end else if (host_wr_in && uml_addr_hit(host_addr_in, ADDR_SCR)) begin
            scratch_reg <= host_data_bus_in;
        end
    end

    assign loopback = modem_control_reg[MCR_LOOP];
    assign auto_cts = modem_control_reg[MCR_AUTO];

    // ------------------------------------------------------------------
    // modem input levels
    // ------------------------------------------------------------------

    // true levels; in loopback the control bits stand in for the pins
    // so diagnostics can toggle status without a modem attached
    always_comb begin
        if (loopback) begin
            cts_level = modem_control_reg[MCR_RTS];
            dsr_level = modem_control_reg[MCR_DTR];
            dcd_level = modem_control_reg[MCR_OUT_B];
        end else begin
            cts_level = ~cts_n_in;
            dsr_level = ~dsr_n_in;
            dcd_level = ~dcd_n_in;
        end
    end

    // ------------------------------------------------------------------
    // host read port and clear-on-read
    // ------------------------------------------------------------------
    uml_host_port u_host_port (
        .ref_clk_in               (ref_clk_in),
        .rst_n_in                 (rst_n_in),
        .host_rd_in               (host_rd_in),
        .read_value_in            (read_value),
        .data_out                 (host_data_bus_out),
        .data_oe_out              (host_data_bus_oe_out),
        .bus_driver_disable_n_out (bus_driver_disable_n_out),
        .rd_start_out             (rd_start)
    );

    // clear at the same edge that snapshots the byte, so nothing is lost
    assign status_clear = rd_start & uml_addr_hit(host_addr_in, ADDR_MSR);

    // ------------------------------------------------------------------
    // change flags
    // ------------------------------------------------------------------

    // clear-to-send change
    uml_change_flag u_cts_flag (
        .ref_clk_in      (ref_clk_in),
        .rst_n_in        (rst_n_in),
        .master_reset_in (master_reset_in),
        .level_in        (cts_level),
        .clear_in        (status_clear),
        .flag_out        (cts_change)
    );

    // data-set-ready change
    uml_change_flag u_dsr_flag (
        .ref_clk_in      (ref_clk_in),
        .rst_n_in        (rst_n_in),
        .master_reset_in (master_reset_in),
        .level_in        (dsr_level),
        .clear_in        (status_clear),
        .flag_out        (dsr_change_flag)
    );

    // carrier detect change
    uml_change_flag u_dcd_flag (
        .ref_clk_in      (ref_clk_in),
        .rst_n_in        (rst_n_in),
        .master_reset_in (master_reset_in),
        .level_in        (dcd_level),
        .clear_in        (status_clear),
        .flag_out        (dcd_change)
    );

    // ------------------------------------------------------------------
    // status assembly and read mux
    // ------------------------------------------------------------------

    // status byte; ring bits 2 and 6 are not carried and read zero
    always_comb begin
        modem_status_reg           = BYTE_ZERO;
        modem_status_reg[MSR_DCTS] = cts_change;
        modem_status_reg[MSR_DSR_CHANGE_FLAG] = dsr_change_flag;
        modem_status_reg[MSR_DDCD] = dcd_change;
        modem_status_reg[MSR_CTS]  = cts_level;
        modem_status_reg[MSR_DSR]  = dsr_level;
        modem_status_reg[MSR_DCD]  = dcd_level;
    end

    // read mux; unlisted addresses belong to neighbours and read zero here
    always_comb begin
        case (host_addr_in)
            ADDR_IER: read_value = int_enable_reg;
            ADDR_MCR: read_value = modem_control_reg;
            ADDR_MSR: read_value = modem_status_reg;
            ADDR_SCR: read_value = scratch_reg;
            default:  read_value = BYTE_ZERO;
        endcase
    end

    // ------------------------------------------------------------------
    // interrupt
    // ------------------------------------------------------------------

    // cts changes are hidden while the hardware handles flow itself
    assign ms_pending = dsr_change_flag | dcd_change
                      | (cts_change & ~auto_cts);

    // timeout counts as received data only in fifo mode
    assign rx_pending = rx_data_avail_in | (rx_timeout_in & fifo_mode_in);

    // level interrupt; drops as soon as every enabled source is serviced
    always_comb begin
        int_next = (int_enable_reg[IER_RLS]  & rx_error_in)
                 | (int_enable_reg[IER_RDA]  & rx_pending)
                 | (int_enable_reg[IER_THRE] & thr_empty_in)
                 | (int_enable_reg[IER_MS]   & ms_pending);
    end

    // registered to keep the pin glitch free, costs one cycle of latency
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            int_out <= 1'b0;
        end else if (master_reset_in) begin
            int_out <= 1'b0;
        end else begin
            int_out <= int_next;
        end
    end

    // ------------------------------------------------------------------
    // transmitter gate
    // ------------------------------------------------------------------

    // without automatic mode the transmitter is never held off here
    assign tx_allowed_next = ~auto_cts | cts_level;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_allowed_out <= 1'b1;
        end else if (master_reset_in) begin
            tx_allowed_out <= 1'b1;
        end else begin
            tx_allowed_out <= tx_allowed_next;
        end
    end

    // ------------------------------------------------------------------
    // modem output pins
    // ------------------------------------------------------------------

    // outputs go inactive high on reset and in loopback, where the
    // control bits stay off the pins and all but MCR_OUT_A are wrapped back internally
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dtr_n_out           <= 1'b1;
            rts_n_out           <= 1'b1;
            user_output_a_n_out <= 1'b1;
            user_output_b_n_out <= 1'b1;
        end else if (master_reset_in || loopback) begin
            dtr_n_out           <= 1'b1;
            rts_n_out           <= 1'b1;
            user_output_a_n_out <= 1'b1;
            user_output_b_n_out <= 1'b1;
        end else begin
            dtr_n_out           <= ~modem_control_reg[MCR_DTR];
            rts_n_out           <= ~modem_control_reg[MCR_RTS];
            user_output_a_n_out <= ~modem_control_reg[MCR_OUT_A];
            user_output_b_n_out <= ~modem_control_reg[MCR_OUT_B];
        end
    end

endmodule // uml_modem_lines
`default_nettype wire

// [verilog/uml_pkg.sv]
`default_nettype none
package uml_pkg;

    // host bus geometry
    localparam int unsigned DATA_W    = 8;
    localparam int unsigned ADDR_W    = 3;

    // register select codes on the host address lines
    localparam logic [2:0] ADDR_IER   = 3'h1;
    localparam logic [2:0] ADDR_MCR   = 3'h4;
    localparam logic [2:0] ADDR_MSR   = 3'h6;
    localparam logic [2:0] ADDR_SCR   = 3'h7;

    // interrupt enable fields
    localparam int unsigned IER_RDA   = 0;
    localparam int unsigned IER_THRE  = 1;
    localparam int unsigned IER_RLS   = 2;
    localparam int unsigned IER_MS    = 3;

    // modem control fields
    localparam int unsigned MCR_DTR   = 0;
    localparam int unsigned MCR_RTS   = 1;
    localparam int unsigned MCR_OUT_A = 2;
    localparam int unsigned MCR_OUT_B = 3;
    localparam int unsigned MCR_LOOP  = 4;
    localparam int unsigned MCR_AUTO  = 5;

    // modem status fields
    localparam int unsigned MSR_DCTS  = 0;
    localparam int unsigned MSR_DSR_CHANGE_FLAG  = 1;
    localparam int unsigned MSR_DDCD  = 3;
    localparam int unsigned MSR_CTS   = 4;
    localparam int unsigned MSR_DSR   = 5;
    localparam int unsigned MSR_DCD   = 7;

    // reset values and writable-bit masks
    localparam logic [7:0] IER_RST    = 8'h00;
    localparam logic [7:0] IER_MASK   = 8'h0f;
    localparam logic [7:0] MCR_RST    = 8'h00;
    localparam logic [7:0] MCR_MASK   = 8'h3f;
    localparam logic [7:0] SCR_RST    = 8'h00;
    localparam logic [7:0] BYTE_ZERO  = 8'h00;

    // true when the host address selects the given register
    function automatic logic uml_addr_hit(input logic [2:0] addr, input logic [2:0] sel);
        uml_addr_hit = (addr == sel);
    endfunction

endpackage
`default_nettype wire
